/* File: shared/gio_pkg.sv */
// Shared constants for the guard interlock output logic.
// Assumes a single 20 MHz system clock and synchronous active-low reset.
`default_nettype none
package gio_pkg;
    // ========================================================================
    // Clock and timing
    // ========================================================================
    localparam int CLK_HZ = 20000000;
    // Longest allowed self-test pulse, in nanoseconds (0.35 ms).
    localparam int TEST_PULSE_MAX_NS = 350000;
    // Longest time rounds down to whole cycles: 7000 cycles.
    localparam int TEST_PULSE_CYC = (TEST_PULSE_MAX_NS / 1000) * (CLK_HZ / 1000000);
    // Spacing between self-test pulses, in microseconds.
    localparam int TEST_PERIOD_US = 10000;
    localparam int TEST_PERIOD_CYC = TEST_PERIOD_US * (CLK_HZ / 1000000);
    // Pulse actually used is half the limit, leaving margin.
    localparam int TEST_PULSE_USED_CYC = TEST_PULSE_CYC / 2;
    // Cycles after a pulse edge before readback is trusted.
    localparam int READBACK_SETTLE_CYC = 8;
    // ========================================================================
    // Actuator code
    // ========================================================================
    localparam int CODE_W = 32;
    localparam int CNT_W = 20;
    localparam logic [CODE_W-1:0] CODE_RESET = 32'h00000000;
    typedef enum logic [1:0] {
        GIO_IDLE,
        GIO_ON,
        GIO_PULSE,
        GIO_FAULT
    } gio_state_t;
endpackage
`default_nettype wire

/* File: hdl/gio_code_store.sv */
// Taught actuator code store; read data come out of a register.
// Assumes the teach-in sequencer writes one code at a time on sys_clk.
`default_nettype none
module gio_code_store
    import gio_pkg::*;
#(
    parameter int WIDTH = CODE_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_code,
    output logic [WIDTH-1:0] rd_code
);
    // ========================================================================
    // Storage
    // ========================================================================
    logic [WIDTH-1:0] code_d;
    logic [WIDTH-1:0] code_q;

    // Hold the code unless a new one is taught.
    always_comb begin
        code_d = code_q;
        if (wr_en) begin
            code_d = wr_code;
        end
    end

    // A reset clears the code to zero, so until taught the exact variant matches only a zero code.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            code_q <= WIDTH'(CODE_RESET);
        end else begin
            code_q <= code_d;
        end
    end

    assign rd_code = code_q;
endmodule
`default_nettype wire

/* File: hdl/gio_outputs.sv */
// Output logic for a transponder-coded guard interlocking switch.
// Assumes actuator presence, code and fault sources are asynchronous pins
// from the reader and monitors; readback pins sense the two output lines.
`default_nettype none
module gio_outputs
    import gio_pkg::*;
#(
    parameter bit EXACT_CODE = 1'b1,
    parameter int PULSE_CYC = TEST_PULSE_USED_CYC,
    parameter int PERIOD_CYC = TEST_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic actuator_present,
    input wire logic type_valid,
    input wire logic [CODE_W-1:0] actuator_code,
    input wire logic teach_active,
    input wire logic teach_wr,
    input wire logic internal_fault,
    input wire logic ch1_readback,
    input wire logic ch2_readback,
    output logic safety_out_ch1,
    output logic safety_out_ch2,
    output logic door_closed_out,
    output logic fault_diag_out,
    output logic fault_indicator
);
    // ========================================================================
    // Input synchronisers
    // ========================================================================
    localparam int NSYNC = CODE_W + 5;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] sync_d;

    // All pins cross two flops; only the second stage is read below.
    always_comb begin
        sync_d = {actuator_present, type_valid, teach_active, teach_wr,
                  internal_fault, actuator_code};
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= sync_d;
            sync2_q <= sync1_q;
        end
    end

    logic present_s, type_s, teach_s, teach_wr_s, fault_s;
    logic [CODE_W-1:0] code_s;
    assign {present_s, type_s, teach_s, teach_wr_s, fault_s, code_s} = sync2_q;

    // Readbacks cross their own two flops, so no gate ever sees a raw line level.
    logic [1:0] rb1_q, rb2_q;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rb1_q <= 2'h0;
            rb2_q <= 2'h0;
        end else begin
            rb1_q <= {rb1_q[0], ch1_readback};
            rb2_q <= {rb2_q[0], ch2_readback};
        end
    end

    // ========================================================================
    // Code judgement
    // ========================================================================
    logic [CODE_W-1:0] taught_code;

    gio_code_store #(.WIDTH(CODE_W)) u_store (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(teach_wr_s && teach_s),
        .wr_code(code_s),
        .rd_code(taught_code)
    );

    // Exact variant compares the full code; type variant only checks type.
    function automatic logic code_ok(input logic valid, input logic [CODE_W-1:0] got,
                                     input logic [CODE_W-1:0] want);
        if (EXACT_CODE) begin
            return valid && (got == want);
        end
        return valid;
    endfunction

    logic permit;
    assign permit = present_s && code_ok(type_s, code_s, taught_code);

    // ========================================================================
    // Output sequencer
    // ========================================================================
    gio_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic fault_q, fault_d;
    logic drive_q, drive_d;

    // The fault latch clears only by reset: a power cycle is the recovery path,
    // so a flickering fault can never re-enable the outputs on its own.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + CNT_W'(1);
        fault_d = fault_q;
        drive_d = 1'b0;
        // Mismatch on outputs that should both be off or both on means a ground fault.
        if (fault_s) begin
            fault_d = 1'b1;
        end
        if (cnt_q >= CNT_W'(READBACK_SETTLE_CYC) && state_q != GIO_IDLE
            && rb1_q[1] != rb2_q[1]) begin
            fault_d = 1'b1;
        end
        if (state_q == GIO_PULSE && cnt_q >= CNT_W'(READBACK_SETTLE_CYC)
            && (rb1_q[1] || rb2_q[1])) begin
            fault_d = 1'b1; // A line shorted to the supply reads high in the gap, when both outputs are off.
        end
        case (state_q)
            GIO_IDLE: begin
                cnt_d = '0;
                // A latched fault blocks any new on request.
                if (fault_q) begin
                    state_d = GIO_FAULT;
                end else if (permit && !teach_s && !fault_s) begin
                    state_d = GIO_ON;
                    drive_d = 1'b1;
                end
            end
            GIO_ON: begin
                drive_d = 1'b1;
                if (fault_d) begin
                    state_d = GIO_FAULT;
                    drive_d = 1'b0;
                end else if (!present_s || !permit || teach_s) begin
                    state_d = GIO_IDLE;
                    drive_d = 1'b0;
                end else if (cnt_q >= CNT_W'(PERIOD_CYC - 1)) begin
                    state_d = GIO_PULSE;
                    cnt_d = '0;
                    drive_d = 1'b0;
                end
            end
            GIO_PULSE: begin
                if (fault_d) begin
                    state_d = GIO_FAULT;
                end else if (!present_s || !permit || teach_s) begin
                    state_d = GIO_IDLE;
                end else if (cnt_q >= CNT_W'(PULSE_CYC - 1)) begin
                    state_d = GIO_ON;
                    cnt_d = '0;
                    drive_d = 1'b1;
                end
            end
            default: begin
                cnt_d = '0;
                fault_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= GIO_IDLE;
            cnt_q <= '0;
            fault_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            fault_q <= fault_d;
            drive_q <= drive_d;
        end
    end

    // ========================================================================
    // Output registers
    // ========================================================================
    logic door_q, diag_q;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            door_q <= 1'b0;
            diag_q <= 1'b0;
        end else begin
            door_q <= present_s;
            diag_q <= fault_d;
        end
    end

    // Both channels come from one flop so they switch together.
    assign safety_out_ch1 = drive_q;
    assign safety_out_ch2 = drive_q;
    assign door_closed_out = door_q;
    assign fault_diag_out = diag_q;
    assign fault_indicator = diag_q;
endmodule
`default_nettype wire

/* File: testbench/gio_checker.sv */
// Checker for the guard interlock outputs, bound to every instance.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module gio_checker #(
    parameter int PULSE_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic actuator_present,
    input wire logic teach_active,
    input wire logic internal_fault,
    input wire logic ch1_readback,
    input wire logic safety_out_ch1,
    input wire logic safety_out_ch2,
    input wire logic door_closed_out,
    input wire logic fault_diag_out,
    input wire logic fault_indicator
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = PULSE_CYC + 1;
    // ==================================================================
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    chk_chan_equal: assert property (safety_out_ch1 == safety_out_ch2)
        else $error("safety channels differ");
    chk_open_off: assert property (!actuator_present [*6] |-> !safety_out_ch1)
        else $error("output on with guard open");
    chk_fault_off: assert property (internal_fault |-> ##5
        (fault_diag_out && !safety_out_ch1))
        else $error("fault did not force outputs off");
    chk_diag_same: assert property (fault_diag_out == fault_indicator)
        else $error("diagnostic output and indicator differ");
    chk_door_follow: assert property (door_closed_out == $past(actuator_present, 3))
        else $error("door output does not follow actuator");
    chk_teach_off: assert property (teach_active [*5] |-> !safety_out_ch1)
        else $error("output on during teach-in");
    chk_rise_permit: assert property ($rose(safety_out_ch1) |->
        $past(actuator_present, 3) && !fault_diag_out)
        else $error("output rose without permission");
    // A dip with the guard closed and no fault must be a short test pulse.
    chk_pulse_short: assert property (($fell(safety_out_ch1) && actuator_present
        && !teach_active && !internal_fault && !fault_diag_out && !ch1_readback)
        |-> ##[1:PW] safety_out_ch1)
        else $error("test pulse too long");
    cover property ($rose(safety_out_ch1));
    cover property ($rose(fault_diag_out));
    cover property ($fell(safety_out_ch1) && door_closed_out);
endmodule
bind gio_outputs gio_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .actuator_present(actuator_present), .teach_active(teach_active),
    .internal_fault(internal_fault), .ch1_readback(ch1_readback),
    .safety_out_ch1(safety_out_ch1), .safety_out_ch2(safety_out_ch2),
    .door_closed_out(door_closed_out), .fault_diag_out(fault_diag_out),
    .fault_indicator(fault_indicator));
`default_nettype wire

/* File: testbench/gio_ctrl_model.sv */
// Downstream safety control and output wiring model.
// Assumes both safety lines are sensed straight back by the device.
`default_nettype none
module gio_ctrl_model #(
    parameter int TOL_CYC = 21
) (
    input wire logic sys_clk,
    input wire logic out_ch1,
    input wire logic out_ch2,
    input wire logic short_en,
    input wire logic gnd_en,
    output logic rb_ch1,
    output logic rb_ch2,
    output logic run_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    int low_cnt = 1000;
    // ==================================================================
    // A short ties both lines to the supply, so pulse gaps read high.
    assign rb_ch1 = short_en | out_ch1;
    // A ground fault on line two holds its readback low while line one follows.
    assign rb_ch2 = !gnd_en && (short_en | out_ch2);
    // Both channels judged together; dips up to the tolerance are bridged.
    always @(posedge sys_clk) begin
        low_cnt <= (out_ch1 && out_ch2) ? 0 : low_cnt + 1;
    end
    assign run_ok = low_cnt <= TOL_CYC;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench: exact-code and type-only instances side by side.
// Assumes the exact-code instance's readback pins see the model's line levels; the type-only one reads its own outputs.
`default_nettype none
module testbench;
    import gio_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 20;
    localparam int PER = 200;
    localparam logic [CODE_W-1:0] CODE_A = 32'h5a3c96e1;
    logic sys_clk = 1'b0, nrst = 1'b0, present = 1'b0, tvalid = 1'b0, teach = 1'b0;
    logic twr = 1'b0, fault = 1'b0, short_en = 1'b0, gnd_en = 1'b0;
    logic [CODE_W-1:0] code = 32'h00000000;
    logic o1, o2, door, diag, ind, rb1, rb2, run_ok, m1, m2;
    int err_count = 0, tests_run = 0, cyc = 0, n;
    gio_outputs #(.EXACT_CODE(1'b1), .PULSE_CYC(PW), .PERIOD_CYC(PER)) dut (.sys_clk(sys_clk),
        .nrst(nrst), .actuator_present(present), .type_valid(tvalid), .actuator_code(code),
        .teach_active(teach), .teach_wr(twr), .internal_fault(fault), .ch1_readback(rb1),
        .ch2_readback(rb2), .safety_out_ch1(o1), .safety_out_ch2(o2), .door_closed_out(door),
        .fault_diag_out(diag), .fault_indicator(ind));
    gio_outputs #(.EXACT_CODE(1'b0), .PULSE_CYC(PW), .PERIOD_CYC(PER)) dut_mc (
        .sys_clk(sys_clk), .nrst(nrst), .actuator_present(present), .type_valid(tvalid),
        .actuator_code(code), .teach_active(teach), .teach_wr(twr), .internal_fault(fault),
        .ch1_readback(m1), .ch2_readback(m2), .safety_out_ch1(m1), .safety_out_ch2(m2),
        .door_closed_out(), .fault_diag_out(), .fault_indicator());
    gio_ctrl_model #(.TOL_CYC(PW + 1)) u_ctrl (.sys_clk(sys_clk), .out_ch1(o1), .out_ch2(o2),
        .short_en(short_en), .gnd_en(gnd_en), .rb_ch1(rb1), .rb_ch2(rb2), .run_ok(run_ok));
    // ==================================================================
    // Clock and hang guard.
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 4000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic chk(input string name, input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        present <= 1'b0;
        fault <= 1'b0;
        short_en <= 1'b0;
        gnd_en <= 1'b0;
        tick(8);
        nrst <= 1'b1;
        tick(2);
    endtask
    // Teach CODE_A with the actuator in the head; outputs must stay off.
    task automatic teach_code();
        teach <= 1'b1;
        twr <= 1'b1;
        present <= 1'b1;
        tvalid <= 1'b1;
        code <= CODE_A;
        tick(10);
        chk("teach_off", o1, 1'b0);
        teach <= 1'b0;
        twr <= 1'b0;
    endtask
    task automatic t_exact();
        teach_code();
        code <= ~CODE_A;
        tick(10);
        chk("wrong_code", o1, 1'b0);
        chk("type_only", m1, 1'b1);
        chk("door_on", door, 1'b1);
        code <= CODE_A;
        tick(6);
        chk("ch1_on", o1, 1'b1);
        chk("ch2_on", o2, 1'b1);
        n = 0;
        while (o1 === 1'b1 && n < PER + 10) begin
            tick(1);
            n++;
        end
        n = 0;
        while (o1 === 1'b0 && n < PW + 10) begin
            tick(1);
            n++;
        end
        chk("pulse_len", n > 0 && n <= PW, 1'b1);
        chk("ctrl_ok", run_ok, 1'b1);
        present <= 1'b0;
        tick(8);
        chk("open_off", o1, 1'b0);
        chk("door_off", door, 1'b0);
    endtask
    task automatic t_fault();
        present <= 1'b1;
        tick(8);
        chk("mc_on", m1, 1'b1);
        fault <= 1'b1;
        tick(8);
        chk("fault_off", m1, 1'b0);
        chk("diag_on", diag, 1'b1);
        chk("led_on", ind, 1'b1);
        fault <= 1'b0;
        present <= 1'b0;
        tick(4);
        present <= 1'b1;
        tick(10);
        chk("stays_off", m1, 1'b0);
    endtask
    task automatic t_short();
        teach_code();
        tick(6);
        chk("on_again", o1, 1'b1);
        short_en <= 1'b1;
        tick(PER + PW + 20);
        chk("short_off", o1, 1'b0);
        chk("short_diag", diag, 1'b1);
    endtask
    // Line two grounded while on: the channels read back differently after settling.
    task automatic t_ground();
        teach_code();
        tick(6);
        chk("on_third", o1, 1'b1);
        gnd_en <= 1'b1;
        tick(16);
        chk("gnd_off", o1, 1'b0);
        chk("gnd_diag", diag, 1'b1);
    endtask
    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_exact();
        do_reset();
        t_fault();
        do_reset();
        t_short();
        do_reset();
        t_ground();
        give_verdict();
    end
endmodule
`default_nettype wire
